// ==== dpllc_top.sv ====
// loop clock control registers, clock source select and stop behaviour
`timescale 1ns/100ps
`include "dpllc_cfg.svh"
module dpllc_top #(parameter logic [15:0] LOCK_CYCLES = `DPLLC_LOCK_CYCLES)
(
   // clocking
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic CE,
   // register port
   input wire logic [23:0] ADDR,
   input wire logic MODE16,
   input wire logic WR,
   input wire logic RD,
   input wire logic [23:0] WDATA,
   output logic [23:0] RDATA,
   // pins and status
   input wire logic LOOP_ENABLE_INIT_PIN,
   input wire logic STOP_STATE,
   input wire logic LOOP_LOCK_IN,
   output logic CORE_FROM_LOOP,
   output logic CORE_CLK_EN,
   output logic LOWPOWER_TICK,
   output logic LOOP_RUN,
   output logic OSC_RUN,
   output logic CRYSTAL_DRIVE_OUTPUT,
   output logic RESERVED_OUT_EN,
   output dpllc_pkg::dpllc_static_t STATIC_CFG,
   output dpllc_pkg::dpllc_factor_t FACTOR
);
   typedef struct packed {
      dpllc_pkg::dpllc_static_t st;
      dpllc_pkg::dpllc_ctrl_t ct;
      dpllc_pkg::dpllc_lock_t lock;
      logic [15:0] lock_count;
      logic init_seen;
      logic [1:0] init_wait;
      logic [1:0] init_sync;
      logic [1:0] stop_sync;
      logic [1:0] lock_sync;
      logic [23:0] rdata;
      logic core_from_loop;
      logic core_en;
      logic lp_tick;
      logic loop_run;
      logic osc_run;
      logic crystal_drive_output;
      logic rsv_en;
      dpllc_pkg::dpllc_static_t st_out;
      dpllc_pkg::dpllc_factor_t factor;
   } dpllc_state_t;
   dpllc_state_t state;
   dpllc_state_t next_state;
   dpllc_pkg::dpllc_factor_t factor;
   logic half_tick;
   logic div_tick;
   logic hit_static;
   logic hit_ctrl;
   function automatic logic addr_hit(input logic [23:0] a, input logic m16,
      input logic [23:0] full, input logic [15:0] short);
      addr_hit = m16 ? (a[15:0] == short) : (a == full);
   endfunction
   dpllc_decode u_decode
   (
      .st(state.st),
      .factor(factor)
   );
   dpllc_divider #(.WIDTH(8)) u_divider
   (
      .clk(CLK),
      .reset_n(RESET_N),
      .ce(CE),
      .div_code(state.ct.low_power_divider),
      .half_tick(half_tick),
      .div_tick(div_tick)
   );
   always_comb
   begin
      hit_static = addr_hit(ADDR, MODE16, `DPLLC_ADDR_STATIC, `DPLLC_ADDR16_STATIC);
      hit_ctrl = addr_hit(ADDR, MODE16, `DPLLC_ADDR_CTRL, `DPLLC_ADDR16_CTRL);
      next_state = state;
      next_state.init_sync = {state.init_sync[0], LOOP_ENABLE_INIT_PIN};
      next_state.stop_sync = {state.stop_sync[0], STOP_STATE};
      next_state.lock_sync = {state.lock_sync[0], LOOP_LOCK_IN};
      // the strap is read only after both synchroniser stages have settled
      if (!state.init_seen)
      begin
         if (state.init_wait == 2'h2)
         begin
            next_state.init_seen = 1'b1;
            next_state.ct.loop_enable = state.init_sync[1];
         end
         else
            next_state.init_wait = state.init_wait + 2'h1;
      end
      else if (WR && hit_ctrl)
         next_state.ct = dpllc_pkg::dpllc_ctrl_t'(WDATA[6:0]);
      if (WR && hit_static)
         next_state.st = dpllc_pkg::dpllc_static_t'(WDATA);
      next_state.rdata = 24'h000000;
      if (RD && hit_static)
         next_state.rdata = state.st;
      else if (RD && hit_ctrl)
         next_state.rdata = {17'h00000, state.ct};
      // lock tracking; divider writes never disturb it
      unique case (state.lock)
         dpllc_pkg::DPLLC_OFF:
            if (state.loop_run)
            begin
               next_state.lock = dpllc_pkg::DPLLC_ACQUIRE;
               next_state.lock_count = '0;
            end
         dpllc_pkg::DPLLC_ACQUIRE:
            if (!state.loop_run)
               next_state.lock = dpllc_pkg::DPLLC_OFF;
            else if (state.lock_sync[1] || state.lock_count >= LOCK_CYCLES - 16'h0001)
               next_state.lock = dpllc_pkg::DPLLC_LOCKED;
            else
               next_state.lock_count = state.lock_count + 16'h0001;
         dpllc_pkg::DPLLC_LOCKED:
            if (!state.loop_run)
               next_state.lock = dpllc_pkg::DPLLC_OFF;
      endcase
      next_state.core_from_loop = state.ct.loop_enable &&
         state.lock == dpllc_pkg::DPLLC_LOCKED;
      next_state.core_en = state.core_from_loop ? 1'b1 : half_tick;
      next_state.lp_tick = div_tick;
      next_state.loop_run = state.ct.loop_enable &&
         (!state.stop_sync[1] || state.ct.stop_state_keepalive);
      next_state.osc_run = !state.stop_sync[1] || state.ct.stop_state_keepalive;
      next_state.crystal_drive_output = state.ct.crystal_driver_disable;
      next_state.rsv_en = !state.ct.reserved_out_disable;
      next_state.st_out = state.st;
      next_state.factor = factor;
   end
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state <= '0;
         state.st.modulator_order <= `DPLLC_RST_ORDER;
         state.st.lock_mode_select <= `DPLLC_RST_LOCKMODE;
         state.st.predivision_factor <= `DPLLC_RST_PDF;
         state.st.fraction_denominator <= `DPLLC_RST_DEN;
         state.st.fraction_numerator <= `DPLLC_RST_NUM;
         state.st.integer_multiplier <= `DPLLC_RST_INT;
         state.ct.low_power_divider <= `DPLLC_RST_DIV;
         state.lock <= dpllc_pkg::DPLLC_OFF;
         state.rsv_en <= 1'b1;
         state.osc_run <= 1'b1;
      end
      else if (CE)
         state <= next_state;
   end
   always_comb
   begin
      RDATA = state.rdata;
      CORE_FROM_LOOP = state.core_from_loop;
      CORE_CLK_EN = state.core_en;
      LOWPOWER_TICK = state.lp_tick;
      LOOP_RUN = state.loop_run;
      OSC_RUN = state.osc_run;
      CRYSTAL_DRIVE_OUTPUT = state.crystal_drive_output;
      RESERVED_OUT_EN = state.rsv_en;
      STATIC_CFG = state.st_out;
      FACTOR = state.factor;
   end
   sequence s_bypass_two;
      (CE && !state.core_from_loop) ##1 (CE && !state.core_from_loop);
   endsequence
   property p_bypass_half;
      @(posedge CLK) disable iff (!RESET_N)
      s_bypass_two ##1 CE |-> CORE_CLK_EN != $past(CORE_CLK_EN);
   endproperty
   a_bypass_half: assert property (p_bypass_half) else $error("bypass clock not halved");
   property p_read_ctrl;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && RD && hit_ctrl && !WR) |=> RDATA == {17'h00000, $past(state.ct)};
   endproperty
   a_read_ctrl: assert property (p_read_ctrl) else $error("control readback wrong");
   property p_write_static;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && WR && hit_static) |=> state.st == $past(WDATA);
   endproperty
   a_write_static: assert property (p_write_static) else $error("static write lost");
   property p_int_floor;
      @(posedge CLK) disable iff (!RESET_N)
      CE |=> FACTOR.integer_part >= 4'h5;
   endproperty
   a_int_floor: assert property (p_int_floor) else $error("integer below five");
   property p_crystal_drive_output;
      @(posedge CLK) disable iff (!RESET_N)
      CE ##1 CE |-> CRYSTAL_DRIVE_OUTPUT == $past(state.ct.crystal_driver_disable);
   endproperty
   a_crystal_drive_output: assert property (p_crystal_drive_output) else $error("crystal drive mismatch");
   property p_loop_src;
      @(posedge CLK) disable iff (!RESET_N)
      CORE_FROM_LOOP |-> $past(state.ct.loop_enable);
   endproperty
   a_loop_src: assert property (p_loop_src) else $error("loop used while disabled");
   property p_stop_keep;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && state.stop_sync[1] && !state.ct.stop_state_keepalive) |=> !LOOP_RUN && !OSC_RUN;
   endproperty
   a_stop_keep: assert property (p_stop_keep) else $error("stop did not halt");
   property p_keep_osc;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && state.ct.stop_state_keepalive && !state.ct.loop_enable) |=> OSC_RUN && !LOOP_RUN;
   endproperty
   a_keep_osc: assert property (p_keep_osc) else $error("keepalive oscillator wrong");
   property p_rsv;
      @(posedge CLK) disable iff (!RESET_N)
      CE |=> RESERVED_OUT_EN == !$past(state.ct.reserved_out_disable);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved output wrong");
   property p_read_static;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && RD && hit_static) |=> RDATA == $past(state.st);
   endproperty
   a_read_static: assert property (p_read_static) else $error("static readback wrong");
   property p_read_none;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && !(RD && (hit_static || hit_ctrl))) |=> RDATA == 24'h000000;
   endproperty
   a_read_none: assert property (p_read_none) else $error("idle read data not zero");
   property p_write_ctrl;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && WR && hit_ctrl && state.init_seen) |=> state.ct == $past(WDATA[6:0]);
   endproperty
   a_write_ctrl: assert property (p_write_ctrl) else $error("control write lost");
   property p_init_load;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && !state.init_seen && state.init_wait == 2'h2) |=>
         state.ct.loop_enable == $past(state.init_sync[1]);
   endproperty
   a_init_load: assert property (p_init_load) else $error("enable not loaded from strap");
   property p_lp_tick;
      @(posedge CLK) disable iff (!RESET_N)
      CE |=> LOWPOWER_TICK == $past(div_tick);
   endproperty
   a_lp_tick: assert property (p_lp_tick) else $error("low-power tick wrong");
   property p_lock_keep;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && state.lock == dpllc_pkg::DPLLC_LOCKED && state.loop_run) |=>
         state.lock == dpllc_pkg::DPLLC_LOCKED;
   endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("lock lost while running");
   property p_loop_core;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && state.ct.loop_enable && state.lock == dpllc_pkg::DPLLC_LOCKED) |=> CORE_FROM_LOOP;
   endproperty
   a_loop_core: assert property (p_loop_core) else $error("locked loop not used");
   property p_bypass_src;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && !state.ct.loop_enable) |=> !CORE_FROM_LOOP;
   endproperty
   a_bypass_src: assert property (p_bypass_src) else $error("bypass source wrong");
   property p_from_loop_en;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && state.core_from_loop) |=> CORE_CLK_EN;
   endproperty
   a_from_loop_en: assert property (p_from_loop_en) else $error("loop clock gated");
   property p_run_normal;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && !state.stop_sync[1]) |=> OSC_RUN && (LOOP_RUN == $past(state.ct.loop_enable));
   endproperty
   a_run_normal: assert property (p_run_normal) else $error("run state wrong");
   property p_keep_loop;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && state.stop_sync[1] && state.ct.stop_state_keepalive && state.ct.loop_enable) |=>
         LOOP_RUN && OSC_RUN;
   endproperty
   a_keep_loop: assert property (p_keep_loop) else $error("keepalive loop stopped");
   property p_static_out;
      @(posedge CLK) disable iff (!RESET_N)
      CE |=> STATIC_CFG == $past(state.st);
   endproperty
   a_static_out: assert property (p_static_out) else $error("static copy wrong");
   property p_factor_range;
      @(posedge CLK) disable iff (!RESET_N)
      CE |=> FACTOR.predivide >= 5'h01 && FACTOR.denominator >= 8'h01;
   endproperty
   a_factor_range: assert property (p_factor_range) else $error("factor zero");
   property p_int_pass;
      @(posedge CLK) disable iff (!RESET_N)
      (CE && state.st.integer_multiplier >= 4'h6) |=>
         FACTOR.integer_part == $past(state.st.integer_multiplier);
   endproperty
   a_int_pass: assert property (p_int_pass) else $error("integer code altered");
   property p_frac_flag;
      @(posedge CLK) disable iff (!RESET_N)
      CE |=> FACTOR.fractional == ($past(state.st.fraction_numerator) != 7'h00);
   endproperty
   a_frac_flag: assert property (p_frac_flag) else $error("fraction flag wrong");
   property p_numerator;
      @(posedge CLK) disable iff (!RESET_N)
      CE |=> FACTOR.numerator == $past(state.st.fraction_numerator);
   endproperty
   a_numerator: assert property (p_numerator) else $error("numerator wrong");
endmodule

// ==== dpllc_cfg.svh ====
// offsets, field positions, reset values and timing counts of the loop clock control
`ifndef DPLLC_CFG_SVH
`define DPLLC_CFG_SVH
`define DPLLC_ADDR_STATIC 24'hffffd0
`define DPLLC_ADDR_CTRL 24'hffffd1
`define DPLLC_ADDR16_STATIC 16'hffd0
`define DPLLC_ADDR16_CTRL 16'hffd1
`define DPLLC_ST_ORDER 23
`define DPLLC_ST_LOCKMODE 22
`define DPLLC_ST_PDF_HI 21
`define DPLLC_ST_PDF_LO 18
`define DPLLC_ST_DEN_HI 17
`define DPLLC_ST_DEN_LO 11
`define DPLLC_ST_NUM_HI 10
`define DPLLC_ST_NUM_LO 4
`define DPLLC_ST_INT_HI 3
`define DPLLC_ST_INT_LO 0
`define DPLLC_CT_DIV_HI 6
`define DPLLC_CT_DIV_LO 4
`define DPLLC_CT_ENABLE 3
`define DPLLC_CT_XTLDIS 2
`define DPLLC_CT_KEEP 1
`define DPLLC_CT_RSVOUT 0
`define DPLLC_RST_ORDER 1'h1
`define DPLLC_RST_LOCKMODE 1'h1
`define DPLLC_RST_PDF 4'h0
`define DPLLC_RST_DEN 7'h00
`define DPLLC_RST_NUM 7'h00
`define DPLLC_RST_INT 4'h8
`define DPLLC_RST_DIV 3'h3
`define DPLLC_INT_MIN 4'h5
`define DPLLC_LOCK_CYCLES 16'h0040
`endif

// ==== dpllc_pkg.sv ====
// types shared by the loop clock control files
package dpllc_pkg;
   typedef struct packed {
      logic modulator_order;
      logic lock_mode_select;
      logic [3:0] predivision_factor;
      logic [6:0] fraction_denominator;
      logic [6:0] fraction_numerator;
      logic [3:0] integer_multiplier;
   } dpllc_static_t;
   typedef struct packed {
      logic [2:0] low_power_divider;
      logic loop_enable;
      logic crystal_driver_disable;
      logic stop_state_keepalive;
      logic reserved_out_disable;
   } dpllc_ctrl_t;
   typedef struct packed {
      logic [4:0] predivide;
      logic [7:0] denominator;
      logic [6:0] numerator;
      logic [3:0] integer_part;
      logic fractional;
   } dpllc_factor_t;
   typedef enum logic [1:0] {DPLLC_OFF, DPLLC_ACQUIRE, DPLLC_LOCKED} dpllc_lock_t;
endpackage

// ==== dpllc_decode.sv ====
// decodes the static register fields into effective factors
`timescale 1ns/100ps
`include "dpllc_cfg.svh"
module dpllc_decode
(
   // raw fields
   input wire dpllc_pkg::dpllc_static_t st,
   // effective values
   output dpllc_pkg::dpllc_factor_t factor
);
   always_comb
   begin
      factor.predivide = {1'b0, st.predivision_factor} + 5'h01;
      factor.denominator = {1'b0, st.fraction_denominator} + 8'h01;
      factor.numerator = st.fraction_numerator;
      factor.integer_part = (st.integer_multiplier < `DPLLC_INT_MIN) ?
         `DPLLC_INT_MIN : st.integer_multiplier;
      factor.fractional = (st.fraction_numerator != 7'h00);
   end
endmodule

// ==== dpllc_divider.sv ====
// reference halving and power-of-two low-power divider as clock enables
`timescale 1ns/100ps
module dpllc_divider #(parameter int WIDTH = 8)
(
   // clocking
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // control
   input wire logic [2:0] div_code,
   // strobes
   output logic half_tick,
   output logic div_tick
);
   typedef struct packed {
      logic half;
      logic [WIDTH-1:0] count;
   } dpllc_div_state_t;
   dpllc_div_state_t state;
   dpllc_div_state_t next_state;
   logic [WIDTH-1:0] limit;
   always_comb
   begin
      limit = WIDTH'((1 << div_code) - 1);
      next_state = state;
      next_state.half = ~state.half;
      if (state.count >= limit)
         next_state.count = '0;
      else
         next_state.count = state.count + 1'b1;
      half_tick = state.half;
      div_tick = (state.count >= limit);
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         state <= '0;
      else if (ce)
         state <= next_state;
   end
endmodule

// ==== dpllc_ref_model.sv ====
// reference source and loop lock model facing the clock control
`timescale 1ns/100ps
module dpllc_ref_model
(
   // clocking
   input wire logic clk,
   input wire logic reset_n,
   // behaviour select and loop state
   input wire logic slow,
   input wire logic loop_run,
   // source side
   output logic ce,
   output logic lock
);
   logic [5:0] cnt;
   // the reference keeps running, so every cycle carries a reference edge
   assign ce = 1'b1;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cnt <= 6'h00;
      else if (!loop_run)
         cnt <= 6'h00;
      else if (cnt != 6'h3f)
         cnt <= cnt + 6'h01;
   end
   // lock comes late or early, and falls as soon as the loop stops
   assign lock = loop_run && (cnt >= (slow ? 6'h14 : 6'h03));
endmodule

// ==== testbench.sv ====
// self-checking bench for the loop clock control
`timescale 1ns/100ps
module testbench;
   typedef struct packed {
      logic [23:0] a;
      logic m;
      logic [23:0] w;
      logic [23:0] r;
      dpllc_pkg::dpllc_factor_t f;
   } dpllc_row_t;
   logic clk, reset_n, ce, mode16, wr, rd, strap, stop, lock, slow;
   logic from_loop, core_en, tick, loop_run, osc_run, crystal_drive_output, rsv_en;
   logic [23:0] addr, wdata, rdata;
   dpllc_pkg::dpllc_static_t stcfg;
   dpllc_pkg::dpllc_factor_t factor;
   int err_count, tests_run, n;
   dpllc_row_t rows [7];

   dpllc_top #(.LOCK_CYCLES(16'h0028)) dut (.CLK(clk), .RESET_N(reset_n), .CE(ce),
      .ADDR(addr), .MODE16(mode16), .WR(wr), .RD(rd), .WDATA(wdata), .RDATA(rdata),
      .LOOP_ENABLE_INIT_PIN(strap), .STOP_STATE(stop), .LOOP_LOCK_IN(lock),
      .CORE_FROM_LOOP(from_loop), .CORE_CLK_EN(core_en), .LOWPOWER_TICK(tick),
      .LOOP_RUN(loop_run), .OSC_RUN(osc_run), .CRYSTAL_DRIVE_OUTPUT(crystal_drive_output),
      .RESERVED_OUT_EN(rsv_en), .STATIC_CFG(stcfg), .FACTOR(factor));
   dpllc_ref_model ref_src (.clk(clk), .reset_n(reset_n), .slow(slow),
      .loop_run(loop_run), .ce(ce), .lock(lock));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [24:0] got, input logic [24:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [23:0] a, input logic m, input logic [23:0] w);
      @(negedge clk);
      addr = a;
      mode16 = m;
      wdata = w;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic reg_rd(input logic [23:0] a, input logic m, input logic [23:0] r);
      @(negedge clk);
      addr = a;
      mode16 = m;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk(25'(rdata), 25'(r));
   endtask

   task automatic wait_lock;
      n = 0;
      while (from_loop !== 1'b1 && n < 60)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      #200000;
      err_count++;
      print_verdict();
   end

   initial
   begin
      // software keeps order, ratio and reserved bits legal except in the refusal rows
      // order follows denominator size, total factor stays at most 15
      // the external source row sets the crystal driver disable
      rows = '{
         '{24'hffffd0, 1'b0, 24'hfffffe, 24'hfffffe, {5'h10, 8'h80, 7'h7f, 4'he, 1'b1}},
         '{24'h00ffd0, 1'b1, 24'h400003, 24'h400003, {5'h01, 8'h01, 7'h00, 4'h5, 1'b0}},
         '{24'hffffd0, 1'b0, 24'h083036, 24'h083036, {5'h03, 8'h07, 7'h03, 4'h6, 1'b1}},
         '{24'hffffd1, 1'b0, 24'hffffff, 24'h00007f, {5'h03, 8'h07, 7'h03, 4'h6, 1'b1}},
         '{24'h00ffd1, 1'b1, 24'h000035, 24'h000035, {5'h03, 8'h07, 7'h03, 4'h6, 1'b1}},
         '{24'hffffd2, 1'b0, 24'h123456, 24'h000000, {5'h03, 8'h07, 7'h03, 4'h6, 1'b1}},
         '{24'h00ffd0, 1'b0, 24'h654321, 24'h000000, {5'h03, 8'h07, 7'h03, 4'h6, 1'b1}}};
      err_count = 0;
      tests_run = 0;
      reset_n = 1'b0;
      mode16 = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 24'h000000;
      wdata = 24'h000000;
      strap = 1'b1;
      stop = 1'b0;
      slow = 1'b1;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (2) @(negedge clk);
      chk(25'(from_loop), 25'h0);
      reg_rd(24'hffffd0, 1'b0, 24'hc00008);
      reg_rd(24'hffffd1, 1'b0, 24'h000038);
      chk(25'({rsv_en, crystal_drive_output}), 25'h2);
      wait_lock();
      @(negedge clk);
      chk(25'({from_loop, core_en}), 25'h3);
      $display("power-up test done");
      for (int i = 0; i < 7; i++)
      begin
         reg_wr(rows[i].a, rows[i].m, rows[i].w);
         reg_rd(rows[i].a, rows[i].m, rows[i].r);
         chk(factor, rows[i].f);
      end
      chk(25'(stcfg), 25'h083036);
      chk(25'({crystal_drive_output, rsv_en}), 25'h2);
      $display("register table test done");
      // second reset in mid-run with the strap low
      reset_n = 1'b0;
      strap = 1'b0;
      slow = 1'b0;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (2) @(negedge clk);
      reg_rd(24'hffffd1, 1'b0, 24'h000030);
      n = 0;
      repeat (8)
      begin
         @(negedge clk);
         n += int'(core_en);
      end
      chk(25'(n), 25'd4);
      chk(25'(from_loop), 25'h0);
      $display("bypass test done");
      reg_wr(24'hffffd1, 1'b0, 24'h000029);
      wait_lock();
      chk(25'(from_loop), 25'h1);
      repeat (8) @(negedge clk);
      n = 0;
      repeat (32)
      begin
         @(negedge clk);
         n += int'(tick);
      end
      chk(25'(n), 25'd8);
      reg_wr(24'hffffd1, 1'b0, 24'h000009);
      n = 0;
      repeat (8)
      begin
         @(negedge clk);
         n += int'(from_loop);
      end
      chk(25'(n), 25'd8);
      $display("divider test done");
      reg_wr(24'hffffd1, 1'b0, 24'h00000b);
      stop = 1'b1;
      repeat (5) @(negedge clk);
      chk(25'({loop_run, osc_run}), 25'h3);
      reg_wr(24'hffffd1, 1'b0, 24'h000003);
      repeat (5) @(negedge clk);
      chk(25'({loop_run, osc_run}), 25'h1);
      reg_wr(24'hffffd1, 1'b0, 24'h000009);
      repeat (5) @(negedge clk);
      chk(25'({loop_run, osc_run}), 25'h0);
      stop = 1'b0;
      $display("stop test done");
      print_verdict();
   end
endmodule
